// *** hw/svr_forward.sv ***
// one event's forwarding stage onto the channel interconnect
// assumes a same-clock event pulse; output is decoded, registered downstream
`timescale 1ns/1ns
`default_nettype none
module svr_forward #(
	parameter int unsigned NUM_CH = 16
) (
	input  wire logic                        evt,
	input  wire logic                        fwd_en,
	input  wire logic [svr_pkg::CHANNEL_INDEX_W-1:0] channel_index,
	output logic      [NUM_CH-1:0]           ch_hit
);
	import svr_pkg::*;

	// ======================================================
	// one-hot channel decode
	always_comb begin
		ch_hit = '0;
		if (evt && fwd_en && (32'(channel_index) < NUM_CH)) begin
			ch_hit[channel_index] = 1'b1;
		end
	end

endmodule // svr_forward
`default_nettype wire

// *** hw/svr_pkg.sv ***
// violation event register bank: shared offsets, field layout, resets
// assumes a 32-bit apb slave port with 12 significant address bits
package svr_pkg;

	// ======================================================
	// bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_EVT = 3;

	// ======================================================
	// register byte offsets
	localparam logic [11:0] OFS_RAM_FLAG    = 12'h100;
	localparam logic [11:0] OFS_FLASH_FLAG  = 12'h104;
	localparam logic [11:0] OFS_PERIPH_FLAG = 12'h108;
	localparam logic [11:0] OFS_RAM_FWD     = 12'h180;
	localparam logic [11:0] OFS_FLASH_FWD   = 12'h184;
	localparam logic [11:0] OFS_PERIPH_FWD  = 12'h188;
	localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h300;
	localparam logic [11:0] OFS_IRQ_SET     = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h308;

	// ======================================================
	// event positions in every per-event vector
	localparam int unsigned EVT_RAM    = 0;
	localparam int unsigned EVT_FLASH  = 1;
	localparam int unsigned EVT_PERIPH = 2;

	// ======================================================
	// field layout
	localparam int unsigned FLAG_BIT     = 0;
	localparam int unsigned CHANNEL_INDEX_LSB    = 0;
	localparam int unsigned CHANNEL_INDEX_W      = 4;
	localparam int unsigned FWD_EN_BIT   = 31;
	localparam int unsigned IRQ_LSB      = 0;
	localparam int unsigned NUM_CH_DOC   = 16;

	// ======================================================
	// reset values
	localparam logic                RST_FLAG   = 1'b0;
	localparam logic                RST_FWD_EN = 1'b0;
	localparam logic [CHANNEL_INDEX_W-1:0]  RST_CHANNEL_INDEX  = 4'h0;
	localparam logic [NUM_EVT-1:0]  RST_IRQ_EN = 3'h0;

	// ======================================================
	// apb answer sequencer
	typedef enum logic [1:0] {
		SVR_IDLE   = 2'b01,
		SVR_ANSWER = 2'b10
	} svr_apb_e;

endpackage

// *** hw/svr_violation_regs.sv ***
// violation flag, forwarding and interrupt-enable registers on apb
// assumes same-clock one-cycle violation pulses from the detection logic
//
// Summary of operation
// - ram violation flag at 0x100 reads 1 once a ram violation happened
// - flash violation flag at 0x104 set on a flash violation
// - peripheral violation flag at 0x108 set on a peripheral violation
// - ram forwarding register at 0x180 holds its channel index
// - forwarding enable bit: 0 sends nowhere, 1 sends to the chosen channel
// - flash forwarding register at 0x184 holds channel index and enable
// - peripheral forwarding register at 0x188 holds channel index and enable
// - interrupt enable register 0x300 holds a read-write ram enable bit
// - same register holds read-write flash and peripheral enable bits
// - writing 1 at 0x304 enables ram interrupt, 0 leaves it alone
// - 0x304 sets flash and peripheral enables, reads back enable state
// - writing 1 at 0x308 disables the matching interrupt, reads state
`timescale 1ns/1ns
`default_nettype none
module svr_violation_regs #(
	parameter int unsigned NUM_CH = svr_pkg::NUM_CH_DOC
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [svr_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [svr_pkg::DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [svr_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        ram_violation,
	input  wire logic                        flash_violation,
	input  wire logic                        peripheral_violation,
	output logic      [NUM_CH-1:0]           evt_channel_pulse,
	output logic                             irq
);
	import svr_pkg::*;

	// ======================================================
	// elaboration check
	if (NUM_CH < 1 || NUM_CH > (1 << CHANNEL_INDEX_W)) begin : g_bad_ch
		$error("NUM_CH must lie between 1 and the channel index range");
	end

	// ======================================================
	// declarations
	svr_apb_e                   state_r;
	svr_apb_e                   state_nxt;
	logic [NUM_EVT-1:0]         evt_in;
	logic [NUM_EVT-1:0]         flag_r;
	logic [NUM_EVT-1:0]         fwd_en_r;
	logic [CHANNEL_INDEX_W-1:0]         channel_index_r [NUM_EVT];
	logic [NUM_EVT-1:0]         irq_en_r;
	logic [NUM_EVT-1:0]         irq_en_nxt;
	logic [NUM_EVT-1:0]         flag_hit;
	logic [NUM_EVT-1:0]         fwd_hit;
	logic [NUM_CH-1:0]          ch_hit [NUM_EVT];
	logic [NUM_CH-1:0]          ch_any;
	logic                       setup;
	logic                       wr_go;
	logic                       mapped;
	logic [DATA_W-1:0]          rd_mux;
	logic [NUM_EVT-1:0]         wr_lo;

	assign evt_in[EVT_RAM]    = ram_violation;
	assign evt_in[EVT_FLASH]  = flash_violation;
	assign evt_in[EVT_PERIPH] = peripheral_violation;

	// ======================================================
	// address decode: three consecutive words from a base
	function automatic logic [NUM_EVT-1:0] word_hit3(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base
	);
		logic [NUM_EVT-1:0] h;
		h = '0;
		for (int i = 0; i < NUM_EVT; i++) begin
			h[i] = (a == base + ADDR_W'(4 * i));
		end
		return h;
	endfunction

	assign flag_hit = word_hit3(paddr, OFS_RAM_FLAG);
	assign fwd_hit  = word_hit3(paddr, OFS_RAM_FWD);
	assign mapped   = (|flag_hit) || (|fwd_hit)
		|| (paddr == OFS_IRQ_ENABLE) || (paddr == OFS_IRQ_SET)
		|| (paddr == OFS_IRQ_CLEAR);

	// ======================================================
	// apb answer sequencer
	// pready is registered, so every transfer takes exactly one
	// access cycle; read data is captured during the setup cycle
	assign setup = psel && !penable;
	assign wr_go = psel && penable && pready && pwrite;

	always_comb begin
		case (state_r)
			SVR_IDLE:   state_nxt = setup ? SVR_ANSWER : SVR_IDLE;
			SVR_ANSWER: state_nxt = setup ? SVR_ANSWER : SVR_IDLE;
			default:    state_nxt = SVR_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= SVR_IDLE;
			pready  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pready  <= (state_nxt == SVR_ANSWER);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && !mapped;
		end
	end

	// ======================================================
	// read mux
	always_comb begin
		rd_mux = '0;
		for (int i = 0; i < NUM_EVT; i++) begin
			if (flag_hit[i]) begin
				rd_mux[FLAG_BIT] = flag_r[i];
			end
			if (fwd_hit[i]) begin
				rd_mux[CHANNEL_INDEX_LSB +: CHANNEL_INDEX_W] = channel_index_r[i];
				rd_mux[FWD_EN_BIT] = fwd_en_r[i];
			end
		end
		if (paddr == OFS_IRQ_ENABLE || paddr == OFS_IRQ_SET
			|| paddr == OFS_IRQ_CLEAR) begin
			rd_mux[IRQ_LSB +: NUM_EVT] = irq_en_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end else if (!psel) begin
			prdata <= '0;
		end
	end

	// ======================================================
	// violation flags
	// an event in the clearing cycle wins, so no violation is lost
	assign wr_lo = wr_go && pstrb[0] ? flag_hit : '0;

	for (genvar g = 0; g < NUM_EVT; g++) begin : g_flag
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				flag_r[g] <= RST_FLAG;
			end else if (evt_in[g]) begin
				flag_r[g] <= 1'b1;
			end else if (wr_lo[g] && !pwdata[FLAG_BIT]) begin
				flag_r[g] <= 1'b0;
			end
		end
	end

	// ======================================================
	// forwarding configuration
	for (genvar g = 0; g < NUM_EVT; g++) begin : g_fwd
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				channel_index_r[g] <= RST_CHANNEL_INDEX;
			end else if (wr_go && fwd_hit[g] && pstrb[0]) begin
				channel_index_r[g] <= pwdata[CHANNEL_INDEX_LSB +: CHANNEL_INDEX_W];
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				fwd_en_r[g] <= RST_FWD_EN;
			end else if (wr_go && fwd_hit[g] && pstrb[3]) begin
				fwd_en_r[g] <= pwdata[FWD_EN_BIT];
			end
		end

		svr_forward #(
			.NUM_CH        (NUM_CH)
		) u_fwd (
			.evt           (evt_in[g]),
			.fwd_en        (fwd_en_r[g]),
			.channel_index (channel_index_r[g]),
			.ch_hit        (ch_hit[g])
		);
	end

	always_comb begin
		ch_any = '0;
		for (int i = 0; i < NUM_EVT; i++) begin
			ch_any = ch_any | ch_hit[i];
		end
	end

	// two events naming one channel merge into a single pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_channel_pulse <= '0;
		end else begin
			evt_channel_pulse <= ch_any;
		end
	end

	// ======================================================
	// interrupt enables
	always_comb begin
		irq_en_nxt = irq_en_r;
		if (wr_go && pstrb[0]) begin
			if (paddr == OFS_IRQ_ENABLE) begin
				irq_en_nxt = pwdata[IRQ_LSB +: NUM_EVT];
			end else if (paddr == OFS_IRQ_SET) begin
				irq_en_nxt = irq_en_r | pwdata[IRQ_LSB +: NUM_EVT];
			end else if (paddr == OFS_IRQ_CLEAR) begin
				irq_en_nxt = irq_en_r & ~pwdata[IRQ_LSB +: NUM_EVT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_r <= RST_IRQ_EN;
		end else begin
			irq_en_r <= irq_en_nxt;
		end
	end

	// one cycle behind the flags, traded for a glitch-free output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flag_r & irq_en_r);
		end
	end

	// ======================================================
	// assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ram_flag_set: assert property (
		ram_violation |=> flag_r[EVT_RAM] ##1 flag_r[EVT_RAM]
			|| $past(wr_lo[EVT_RAM]))
		else $error("ram flag not set by a violation");

	a_flash_flag_set: assert property (
		flash_violation |=> flag_r[EVT_FLASH])
		else $error("flash flag not set by a violation");

	a_periph_flag_set: assert property (
		peripheral_violation |=> flag_r[EVT_PERIPH])
		else $error("peripheral flag not set by a violation");

	a_flag_sticky: assert property (
		flag_r[EVT_RAM] && !(wr_lo[EVT_RAM] && !pwdata[FLAG_BIT])
			|=> flag_r[EVT_RAM])
		else $error("ram flag dropped without a clearing write");

	a_flag_clear: assert property (
		wr_lo[EVT_FLASH] && !pwdata[FLAG_BIT] && !flash_violation
			|=> !flag_r[EVT_FLASH])
		else $error("flash flag survived a clearing write");

	a_fwd_route: assert property (
		ram_violation && fwd_en_r[EVT_RAM]
			&& (32'(channel_index_r[EVT_RAM]) < NUM_CH)
			|=> evt_channel_pulse[$past(channel_index_r[EVT_RAM])])
		else $error("ram violation not forwarded to its channel");

	a_fwd_quiet: assert property (
		(evt_in & fwd_en_r) == '0 |=> evt_channel_pulse == '0)
		else $error("channel pulse without an enabled event");

	// irq follows only when the ram flag is up as well
	a_irq_set_bit: assert property (
		wr_go && pstrb[0] && paddr == OFS_IRQ_SET && pwdata[IRQ_LSB]
			|=> irq_en_r[EVT_RAM]
			##1 (irq || !$past(flag_r[EVT_RAM])))
		else $error("interrupt set write did not enable");

	a_set_keeps: assert property (
		wr_go && pstrb[0] && paddr == OFS_IRQ_SET
			|=> (irq_en_r & $past(irq_en_r)) == $past(irq_en_r))
		else $error("interrupt set write dropped an enable");

	a_enable_write: assert property (
		wr_go && pstrb[0] && paddr == OFS_IRQ_ENABLE
			|=> irq_en_r == $past(pwdata[IRQ_LSB +: NUM_EVT]))
		else $error("enable register write not taken");

	a_flag_read: assert property (
		setup && !pwrite && flag_hit[EVT_RAM]
			|=> prdata[FLAG_BIT] == $past(flag_r[EVT_RAM]))
		else $error("ram flag not returned on read");

	a_flash_route: assert property (
		flash_violation && fwd_en_r[EVT_FLASH]
			&& (32'(channel_index_r[EVT_FLASH]) < NUM_CH)
			|=> evt_channel_pulse[$past(channel_index_r[EVT_FLASH])])
		else $error("flash violation not forwarded to its channel");

	a_periph_route: assert property (
		peripheral_violation && fwd_en_r[EVT_PERIPH]
			&& (32'(channel_index_r[EVT_PERIPH]) < NUM_CH)
			|=> evt_channel_pulse[$past(channel_index_r[EVT_PERIPH])])
		else $error("peripheral violation not forwarded");

	a_irq_clear_bit: assert property (
		wr_go && pstrb[0] && paddr == OFS_IRQ_CLEAR
			&& pwdata[IRQ_LSB + EVT_FLASH]
			|=> !irq_en_r[EVT_FLASH])
		else $error("interrupt clear write did not disable");

	a_irq_level: assert property (
		(|(flag_r & irq_en_r)) |=> irq)
		else $error("interrupt missing with an enabled flag");

	a_irq_low: assert property (
		!(|(flag_r & irq_en_r)) |=> !irq)
		else $error("interrupt raised with no enabled flag");

	a_enable_read: assert property (
		setup && !pwrite && paddr == OFS_IRQ_SET
			|=> prdata[IRQ_LSB +: NUM_EVT] == $past(irq_en_r) && pready)
		else $error("enable state not returned on read");

endmodule // svr_violation_regs
`default_nettype wire

// *** verif/svr_partner.sv ***
// far side model: violation sources and the channel interconnect
// assumes the bench calls fire() and reads hits[] between transfers
`timescale 1ns/1ns
`default_nettype none
module svr_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] chan,
	output logic      [2:0]  viol
);
	int hits [16];
	initial viol = 3'h0;
	// ======================================================
	// sources
	// one-cycle pulse, as the detector gives it
	task automatic fire(input int k);
		@(posedge pclk);
		viol[k] <= 1'b1;
		@(posedge pclk);
		viol <= 3'h0;
	endtask
	// ======================================================
	// interconnect
	// every cycle counted, so a lost or doubled pulse shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) begin
				hits[i] <= 0;
			end
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (chan[i] === 1'b1) begin
					hits[i] <= hits[i] + 1;
				end
			end
		end
	end
endmodule // svr_partner
`default_nettype wire

// *** verif/svr_violation_regs_test.sv ***
// bench: apb master tasks and directed register and event tests
// assumes the partner model drives the violation inputs
`timescale 1ns/1ns
`default_nettype none
module svr_violation_regs_test;
	import svr_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [3:0]  lanes;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  viol;
	logic [15:0] chan;
	logic        irq;
	logic [31:0] rdat;
	logic        rerr;
	int          mismatches;
	int          total_checks;
	int          cyc;
	logic [11:0] ofs [9] = '{OFS_RAM_FLAG, OFS_FLASH_FLAG, OFS_PERIPH_FLAG,
		OFS_RAM_FWD, OFS_FLASH_FWD, OFS_PERIPH_FWD,
		OFS_IRQ_ENABLE, OFS_IRQ_SET, OFS_IRQ_CLEAR};

	svr_violation_regs #(.NUM_CH(16)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ram_violation(viol[0]), .flash_violation(viol[1]),
		.peripheral_violation(viol[2]), .evt_channel_pulse(chan),
		.irq(irq)
	);
	svr_partner p (.pclk(pclk), .presetn(presetn), .chan(chan), .viol(viol));

	// ======================================================
	// clock, timeout
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// tests need well under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			summarize();
		end
	end
	// ======================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// holds the request until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? lanes : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic chk_irq(input logic e);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ======================================================
	// tests
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{mismatches, total_checks, cyc} = '0;
		lanes = 4'hf;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd(ofs[i], 32'h0);
		end
		xfer(1'b0, 12'h10c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		wr(OFS_RAM_FWD, 32'h80000005);
		rd(OFS_RAM_FWD, 32'h80000005);
		wr(OFS_FLASH_FWD, 32'h00000003);
		rd(OFS_FLASH_FWD, 32'h00000003);
		wr(OFS_PERIPH_FWD, 32'h8000000f);
		rd(OFS_PERIPH_FWD, 32'h8000000f);
		p.fire(0);
		p.fire(1);
		p.fire(2);
		chk_irq(1'b0);
		chk(p.hits[5], 32'h1);
		chk(p.hits[3], 32'h0);
		chk(p.hits[15], 32'h1);
		rd(OFS_RAM_FLAG, 32'h1);
		rd(OFS_FLASH_FLAG, 32'h1);
		rd(OFS_PERIPH_FLAG, 32'h1);
		wr(OFS_IRQ_ENABLE, 32'h2);
		rd(OFS_IRQ_ENABLE, 32'h2);
		chk_irq(1'b1);
		wr(OFS_IRQ_SET, 32'h1);
		rd(OFS_IRQ_ENABLE, 32'h3);
		wr(OFS_IRQ_SET, 32'h0);
		rd(OFS_IRQ_ENABLE, 32'h3);
		wr(OFS_IRQ_SET, 32'h4);
		rd(OFS_IRQ_SET, 32'h7);
		wr(OFS_IRQ_CLEAR, 32'h2);
		rd(OFS_IRQ_CLEAR, 32'h5);
		rd(OFS_IRQ_ENABLE, 32'h5);
		// byte lanes: enable lives in lane 3, channel index in lane 0
		lanes = 4'h8;
		wr(OFS_FLASH_FWD, 32'h8000000c);
		rd(OFS_FLASH_FWD, 32'h80000003);
		lanes = 4'h1;
		wr(OFS_FLASH_FWD, 32'h0000000a);
		rd(OFS_FLASH_FWD, 32'h8000000a);
		lanes = 4'he;
		wr(OFS_PERIPH_FLAG, 32'h0);
		rd(OFS_PERIPH_FLAG, 32'h1);
		lanes = 4'hf;
		p.fire(1);
		wr(OFS_RAM_FLAG, 32'h1);
		p.fire(0);
		rd(OFS_RAM_FLAG, 32'h1);
		chk(p.hits[10], 32'h1);
		chk(p.hits[5], 32'h2);
		wr(OFS_RAM_FLAG, 32'h0);
		rd(OFS_RAM_FLAG, 32'h0);
		chk_irq(1'b1);
		wr(OFS_PERIPH_FLAG, 32'h0);
		chk_irq(1'b0);
		// reset in mid-run clears flags and forwarding setup
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_FLASH_FWD, 32'h0);
		rd(OFS_FLASH_FLAG, 32'h0);
		rd(OFS_IRQ_ENABLE, 32'h0);
		chk_irq(1'b0);
		summarize();
	end
endmodule // svr_violation_regs_test
`default_nettype wire
